// ---- core/mri_exec.sv ----
// Executor for register moves, no-operation and returns
//
// What this block does
// - Move-file copies addressed register to working register or back to itself.
// - Move-file sets zero flag from moved value for either destination.
// - Store-working writes working register to addressed file, flags untouched.
// - Load-literal puts 8-bit immediate into working register, flags untouched.
// - Interrupt return pops stack into program counter over two cycles.
// - Interrupt return also sets global interrupt enable, bit 7 of control.
// - Literal return loads immediate into working register, flags untouched.
// - Literal return loads program counter from popped stack top, two cycles.
// - Subroutine return pops stack into counter, two cycles, enable untouched.
// - Interrupt with global enable set vectors to address 0004h.
`timescale 1ns/1ps
module mri_exec
    import mri_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Instruction cycle enable from the core divider
    input wire logic cyc_en,
    // Program memory
    input wire logic [13:0] instr,
    output logic [12:0] pc,
    // File register port
    input wire logic [7:0] file_rdata,
    output logic [6:0] file_addr,
    output logic [7:0] file_wdata,
    output logic file_we,
    // Stack
    input wire logic [12:0] stack_top,
    output logic stack_pop,
    output logic stack_push,
    output logic [12:0] stack_push_data,
    // Interrupt request, already on this clock
    input wire logic irq_req,
    // Core state
    output logic [7:0] working,
    output logic zero_flag,
    output logic [7:0] interrupt_control_reg,
    output logic global_irq_enable,
    output logic unhandled
);
    mri_dec_if dec_bus ();

    mri_decode u_dec (
        .instr(instr),
        .dec(dec_bus)
    );

    mri_state_t state_r, state_nxt;
    logic [12:0] pc_r, pc_nxt;
    logic [7:0] w_r, w_nxt;
    logic z_r, z_nxt;
    logic [7:0] ictl_r, ictl_nxt;
    logic [6:0] fa_r, fa_nxt;
    logic [7:0] fd_r, fd_nxt;
    logic fwe_r, fwe_nxt;
    logic pop_r, pop_nxt;
    logic push_r, push_nxt;
    logic [12:0] pushd_r, pushd_nxt;
    logic unh_r, unh_nxt;
    // Interrupt entry pre-empts the word in hand and is never taken in a flush
    logic take_irq;
    logic exec_slot;

    function automatic logic is_zero(input logic [7:0] v);
        return v == 8'h00;
    endfunction : is_zero

    assign take_irq = irq_req && ictl_r[GIE_BIT];
    // Working register, flag and file writes change only where a word really executes
    assign exec_slot = cyc_en && (state_r == MRI_EXEC) && !take_irq;

    // Program flow: counter, stack strobes, enable bit and cycle state
    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        ictl_nxt = ictl_r;
        pop_nxt = 1'b0;
        push_nxt = 1'b0;
        pushd_nxt = pushd_r;
        if (cyc_en) begin
            case (state_r)
                MRI_EXEC: begin
                    if (take_irq) begin
                        // Vector; current word re-fetched after return
                        pc_nxt = ISR_VECTOR;
                        push_nxt = 1'b1;
                        pushd_nxt = pc_r;
                        ictl_nxt[GIE_BIT] = 1'b0;
                        state_nxt = MRI_FLUSH;
                    end else begin
                        pc_nxt = pc_r + PC_STEP;
                        case (dec_bus.kind)
                            MRI_K_RETI: begin
                                pc_nxt = stack_top;
                                pop_nxt = 1'b1;
                                ictl_nxt[GIE_BIT] = 1'b1;
                                state_nxt = MRI_FLUSH;
                            end
                            MRI_K_RETL: begin
                                pc_nxt = stack_top;
                                pop_nxt = 1'b1;
                                state_nxt = MRI_FLUSH;
                            end
                            MRI_K_RET: begin
                                // Enable bit left as it was
                                pc_nxt = stack_top;
                                pop_nxt = 1'b1;
                                state_nxt = MRI_FLUSH;
                            end
                            default: begin
                                // One-cycle instructions only advance the counter
                            end
                        endcase
                    end
                end
                MRI_FLUSH: begin
                    // Second cycle discards the prefetched word
                    state_nxt = MRI_EXEC;
                end
                default: state_nxt = MRI_EXEC;
            endcase
        end
    end

    // Data path: working register, zero flag, file port and decode fault
    always_comb begin
        w_nxt = w_r;
        z_nxt = z_r;
        fa_nxt = dec_bus.faddr;
        fd_nxt = fd_r;
        fwe_nxt = 1'b0;
        unh_nxt = 1'b0;
        if (exec_slot) begin
            case (dec_bus.kind)
                MRI_K_NOP: begin
                end
                MRI_K_MOVE_FILE_INSTR: begin
                    if (dec_bus.dest_file) begin
                        // Written back unchanged; only the flag matters
                        fd_nxt = file_rdata;
                        fwe_nxt = 1'b1;
                    end else begin
                        w_nxt = file_rdata;
                    end
                    z_nxt = is_zero(file_rdata);
                end
                MRI_K_STW: begin
                    // Flags deliberately not touched
                    fd_nxt = w_r;
                    fwe_nxt = 1'b1;
                end
                MRI_K_LDL: begin
                    w_nxt = dec_bus.lit;
                end
                MRI_K_RETL: begin
                    w_nxt = dec_bus.lit;
                end
                MRI_K_RETI, MRI_K_RET: begin
                    // Flow group does all the work of these
                end
                default: begin
                    // Outside this group; flagged, treated as no-op
                    unh_nxt = 1'b1;
                end
            endcase
        end
    end

    // Flow group registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= MRI_EXEC;
            pc_r <= RESET_VECTOR;
            ictl_r <= INTERRUPT_CONTROL_REG_RESET;
            pop_r <= 1'b0;
            push_r <= 1'b0;
            pushd_r <= 13'h0000;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            ictl_r <= ictl_nxt;
            pop_r <= pop_nxt;
            push_r <= push_nxt;
            pushd_r <= pushd_nxt;
        end
    end

    // Data group registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            w_r <= W_RESET;
            z_r <= 1'b0;
            fa_r <= 7'h00;
            fd_r <= 8'h00;
            fwe_r <= 1'b0;
            unh_r <= 1'b0;
        end else begin
            w_r <= w_nxt;
            z_r <= z_nxt;
            fa_r <= fa_nxt;
            fd_r <= fd_nxt;
            fwe_r <= fwe_nxt;
            unh_r <= unh_nxt;
        end
    end

    assign pc = pc_r;
    assign working = w_r;
    assign zero_flag = z_r;
    assign interrupt_control_reg = ictl_r;
    assign global_irq_enable = ictl_r[GIE_BIT];
    assign file_addr = fa_r;
    assign file_wdata = fd_r;
    assign file_we = fwe_r;
    assign stack_pop = pop_r;
    assign stack_push = push_r;
    assign stack_push_data = pushd_r;
    assign unhandled = unh_r;
endmodule : mri_exec

// ---- include/mri_pkg.sv ----
// Package for the move and return instruction executor
package mri_pkg;
    localparam int WORD_W = 14;
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int PC_W = 13;
    // Opcode patterns for the single-word instructions
    localparam logic [13:0] OP_NOP = 14'h0000;
    localparam logic [13:0] OP_RET = 14'h0008;
    localparam logic [13:0] OP_RETI = 14'h0009;
    localparam logic [5:0] OPH_MOVE_FILE_INSTR = 6'h08;
    localparam logic [6:0] OPH_STW = 7'h01;
    localparam logic [3:0] OPH_LDL = 4'hc;
    localparam logic [3:0] OPH_RETL = 4'hd;
    localparam int DEST_BIT = 7;
    localparam int LIT_MSB = 7;
    localparam int GIE_BIT = 7;
    localparam logic [12:0] ISR_VECTOR = 13'h0004;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [7:0] INTERRUPT_CONTROL_REG_RESET = 8'h00;
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [12:0] PC_STEP = 13'h0001;

    typedef enum logic [1:0] {
        MRI_EXEC = 2'b00,
        MRI_FLUSH = 2'b01
    } mri_state_t;

    typedef enum logic [2:0] {
        MRI_K_NOP,
        MRI_K_MOVE_FILE_INSTR,
        MRI_K_STW,
        MRI_K_LDL,
        MRI_K_RETI,
        MRI_K_RETL,
        MRI_K_RET,
        MRI_K_OTHER
    } mri_kind_t;
endpackage : mri_pkg

// ---- include/mri_dec_if.sv ----
// Decoded instruction fields passed from decoder to executor
`timescale 1ns/1ps
interface mri_dec_if;
    import mri_pkg::*;
    mri_pkg::mri_kind_t kind;
    logic [6:0] faddr;
    logic dest_file;
    logic [7:0] lit;
    modport dec (output kind, faddr, dest_file, lit);
    modport exe (input kind, faddr, dest_file, lit);
endinterface : mri_dec_if

// ---- core/mri_decode.sv ----
// Instruction word decoder for the move and return group
`timescale 1ns/1ps
module mri_decode
    import mri_pkg::*;
(
    // Instruction word
    input wire logic [13:0] instr,
    // Decoded fields
    mri_dec_if.dec dec
);
    function automatic mri_kind_t classify(input logic [13:0] w);
        if (w == OP_NOP) return MRI_K_NOP;
        if (w == OP_RET) return MRI_K_RET;
        if (w == OP_RETI) return MRI_K_RETI;
        if (w[13:8] == OPH_MOVE_FILE_INSTR) return MRI_K_MOVE_FILE_INSTR;
        if (w[13:7] == OPH_STW) return MRI_K_STW;
        // Literal load ignores its two low opcode bits
        if (w[13:10] == OPH_LDL) return MRI_K_LDL;
        if (w[13:10] == OPH_RETL) return MRI_K_RETL;
        return MRI_K_OTHER;
    endfunction : classify

    always_comb begin
        dec.kind = classify(instr);
        dec.faddr = instr[FADDR_W-1:0];
        dec.dest_file = instr[DEST_BIT];
        dec.lit = instr[LIT_MSB:0];
    end
endmodule : mri_decode

// ---- sim/mri_exec_properties.sv ----
// Port-level checks for the move and return executor
`timescale 1ns/1ps
module mri_exec_properties
    import mri_pkg::*;
(
    // Clock, reset and strobes
    input wire logic clk_sys, rst_n, cyc_en, file_we, stack_pop, stack_push, irq_req,
    input wire logic zero_flag, global_irq_enable,
    // Buses
    input wire logic [13:0] instr,
    input wire logic [12:0] pc, stack_top, stack_push_data,
    input wire logic [7:0] file_rdata, file_wdata, working,
    input wire logic [6:0] file_addr
);
    logic pend_r;
    logic go;
    logic ex;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_r <= 1'b0;
        end else begin
            pend_r <= (pend_r | stack_pop | stack_push) & ~cyc_en;
        end
    end
    // Slot after a pop or push is a flush, so no instruction is judged there
    assign go = cyc_en & ~stack_pop & ~stack_push & ~pend_r;
    assign ex = go & ~(irq_req & global_irq_enable);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    ldl_load_a: assert property (ex && instr[13:10] == OPH_LDL
        |=> working == $past(instr[7:0]) && $stable(zero_flag)) else $error("literal load");
    move_file_instr_move_a: assert property (ex && instr[13:8] == OPH_MOVE_FILE_INSTR
        |=> file_we == $past(instr[DEST_BIT]) && (file_we ? file_wdata : working) == $past(file_rdata)
        && zero_flag == ($past(file_rdata) == 8'h00)) else $error("file move");
    stw_store_a: assert property (ex && instr[13:7] == OPH_STW
        |=> file_we && file_wdata == $past(working) && file_addr == $past(instr[6:0])
        && $stable(zero_flag)) else $error("working store");
    retl_pop_a: assert property (ex && instr[13:10] == OPH_RETL
        |=> stack_pop && pc == $past(stack_top) && working == $past(instr[7:0])) else $error("literal return");
    reti_pop_a: assert property (ex && instr == OP_RETI
        |=> stack_pop && pc == $past(stack_top) && global_irq_enable ##1 !stack_pop) else $error("irq return");
    ret_pop_a: assert property (ex && instr == OP_RET
        |=> stack_pop && pc == $past(stack_top) && $stable(global_irq_enable) && $stable(zero_flag))
        else $error("sub return");
    vec_entry_a: assert property (go && irq_req && global_irq_enable
        |=> pc == ISR_VECTOR && stack_push && stack_push_data == $past(pc)) else $error("irq vector");
    nop_idle_a: assert property (ex && instr == OP_NOP
        |=> pc == $past(pc) + PC_STEP && $stable(working) && !file_we && !stack_pop) else $error("no-op");
endmodule : mri_exec_properties

// ---- sim/mri_mem.sv ----
// Program memory and file register model facing the executor
`timescale 1ns/1ps
module mri_mem (
    // Clock
    input wire logic clk_sys,
    // Fetch
    input wire logic [12:0] pc,
    output logic [13:0] instr,
    // File registers
    input wire logic [6:0] file_addr,
    input wire logic [7:0] file_wdata,
    input wire logic file_we,
    output logic [7:0] file_rdata
);
    logic [13:0] rom [8192] = '{default: 14'h0000};
    logic [7:0] fr [128] = '{default: 8'h3c};
    // Combinational reads: the executor decodes the word in its fetch cycle
    assign instr = rom[pc];
    assign file_rdata = fr[instr[6:0]];
    always @(posedge clk_sys) begin
        if (file_we) begin
            fr[file_addr] <= file_wdata;
        end
    end
endmodule : mri_mem

// ---- sim/testbench.sv ----
// Self-checking bench for the move and return executor
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic irq_req = 1'b0;
    logic cyc_en = 1'b1;
    logic [12:0] stack_top = 13'h0000;
    logic [13:0] instr;
    logic [12:0] pc, stack_push_data;
    logic [7:0] file_rdata, file_wdata, working, interrupt_control_reg;
    logic [6:0] file_addr;
    logic file_we, stack_pop, stack_push, zero_flag, global_irq_enable, unhandled;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
    always #5 clk_sys = ~clk_sys;
    mri_exec i_mri_exec (.*);
    mri_mem i_mri_mem (.*);
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic start();
        rst_n = 1'b0;
        step(2);
        rst_n = 1'b1;
    endtask : start
    task automatic test_moves();
        i_mri_mem.rom[0:6] = '{14'h30a5, 14'h0090, 14'h3000, 14'h0810, 14'h0891, 14'h0000, 14'h3407};
        i_mri_mem.rom[13'h0123] = 14'h3011;
        i_mri_mem.fr[7'h11] = 8'h00;
        stack_top = 13'h0123;
        start();
        step(1); `CHK(working, 8'ha5)
        step(1); `CHK({file_we, file_addr, file_wdata}, {1'b1, 7'h10, 8'ha5})
        step(1); `CHK({working, zero_flag}, {8'h00, 1'b0})
        step(1); `CHK({working, zero_flag, file_we}, {8'ha5, 1'b0, 1'b0})
        step(1); `CHK({working, zero_flag, file_we, file_wdata}, {8'ha5, 1'b1, 1'b1, 8'h00})
        step(1); `CHK({pc, working, zero_flag, file_we}, {13'h0006, 8'ha5, 1'b1, 1'b0})
        step(1); `CHK({pc, working, stack_pop, zero_flag}, {13'h0123, 8'h07, 1'b1, 1'b1})
        // Flush slot, then the word at the popped address runs
        step(2); `CHK({pc, working}, {13'h0124, 8'h11})
        $display("test_moves done");
    endtask : test_moves
    task automatic test_irq();
        i_mri_mem.rom[0] = 14'h0009;
        i_mri_mem.rom[4] = 14'h0008;
        stack_top = 13'h0040;
        start();
        step(1); `CHK({pc, interrupt_control_reg, stack_pop}, {13'h0040, 8'h80, 1'b1})
        step(1);
        irq_req = 1'b1;
        stack_top = 13'h0041;
        step(1); `CHK({pc, stack_push, stack_push_data, global_irq_enable}, {13'h0004, 1'b1, 13'h0040, 1'b0})
        irq_req = 1'b0;
        step(2); `CHK({pc, stack_pop, global_irq_enable, stack_push}, {13'h0041, 1'b1, 1'b0, 1'b0})
        $display("test_irq done");
    endtask : test_irq
    task automatic test_enable();
        i_mri_mem.rom[0] = 14'h3f00;
        i_mri_mem.rom[1] = 14'h0008;
        i_mri_mem.rom[13'h0010] = 14'h3055;
        stack_top = 13'h0010;
        cyc_en = 1'b0;
        start();
        // Divider pulses: counter and state hold between them, strobes drop back to 0
        step(1); `CHK({pc, unhandled}, {13'h0000, 1'b0})
        cyc_en = 1'b1;
        step(1); `CHK({pc, unhandled}, {13'h0001, 1'b1})
        cyc_en = 1'b0;
        step(1); `CHK({pc, unhandled}, {13'h0001, 1'b0})
        cyc_en = 1'b1;
        step(1); `CHK({pc, stack_pop}, {13'h0010, 1'b1})
        cyc_en = 1'b0;
        step(1);
        cyc_en = 1'b1;
        step(1); `CHK({pc, working, stack_pop}, {13'h0010, 8'h00, 1'b0})
        step(1); `CHK({pc, working}, {13'h0011, 8'h55})
        $display("test_enable done");
    endtask : test_enable
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    // All tests need under a hundred cycles; the ceiling leaves ample margin
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        test_moves();
        test_irq();
        test_enable();
        conclude();
    end
endmodule : testbench
bind mri_exec mri_exec_properties i_mri_exec_properties (.*);
